// file: verilog/scda_pkg.sv
package scda_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// Register offsets.
	localparam logic [7:0] OFF_SERIAL_ID_BYTE0 = 8'h00;
	localparam logic [7:0] OFF_SERIAL_ID_BYTE1 = 8'h01;
	localparam logic [7:0] OFF_SERIAL_ID_BYTE2 = 8'h02;
	localparam logic [7:0] OFF_SERIAL_ID_BYTE3 = 8'h03;
	localparam logic [7:0] OFF_RESERVED_FACTORY_A = 8'h04;
	localparam logic [7:0] OFF_RESERVED_FACTORY_B = 8'h05;
	localparam logic [7:0] OFF_FACTORY_CONFIG_BYTE = 8'h06;
	localparam logic [7:0] OFF_PART_NUMBER_CODE = 8'h08;
	localparam logic [7:0] OFF_DEVICE_CONTROL_REG = 8'h0A;
	localparam logic [7:0] OFF_DEVICE_CONFIG_REG = 8'h0B;
	localparam logic [7:0] OFF_AXIS_CONFIG_REG = 8'h0C;
	localparam logic [7:0] OFF_ARMING_CONFIG_REG = 8'h0E;
	localparam logic [7:0] OFF_ARMING_THRESHOLD_POS_REG = 8'h10;
	localparam logic [7:0] OFF_ARMING_THRESHOLD_NEG_REG = 8'h12;
	localparam logic [7:0] OFF_DEVICE_STATUS_REG = 8'h14;
	localparam logic [7:0] OFF_EVENT_COUNT_REG = 8'h15;
	localparam logic [7:0] OFF_OFFSET_CORRECTION_VALUE = 8'h16;
	localparam logic [7:0] OFF_RESERVED_UPPER_A = 8'h1C;
	localparam logic [7:0] OFF_RESERVED_UPPER_B = 8'h1D;

	// Field positions.
	localparam int CTL_RES1_BIT = 7;
	localparam int CTL_RES0_BIT = 6;
	localparam int CFG_ENDINIT_BIT = 5;
	localparam int STAT_CRC_ERR_BIT = 6;
	localparam int STAT_DEVRES_BIT = 0;
	localparam int SERIAL_LOT_LSB = 13;

	// Writable and status-input bit masks; reserved bits are stored or read as zero.
	localparam logic [7:0] DEV_CFG_MASK = 8'h3F;
	localparam logic [7:0] AXIS_MASK = 8'h8F;
	localparam logic [7:0] ARM_MASK = 8'h3F;
	localparam logic [7:0] STAT_IN_MASK = 8'h3A;

	// Reset values and CRC parameters.
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [7:0] CRC_INIT = 8'hFF;
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam int OTP_CRC_BYTES = 8;
	localparam int CFG_CRC_BYTES = 5;

	typedef enum logic [2:0] {
		K_OTP, K_RW, K_RO, K_RSVD, K_INV
	} scda_kind_t;

	typedef enum logic [1:0] {
		SEQ_IDLE, SEQ_ONE, SEQ_TWO
	} scda_seq_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} scda_req_t;

	typedef struct packed {
		logic valid;
		logic invalid;
		logic [DATA_W-1:0] rdata;
	} scda_rsp_t;

	typedef struct packed {
		logic [31:0] serial;
		logic [7:0] rsv_a;
		logic [7:0] rsv_b;
		logic [7:0] fct_cfg;
		logic [7:0] part_num;
		logic [7:0] crc;
	} scda_otp_t;

	typedef struct packed {
		logic [18:0] lot;
		logic [12:0] unit;
	} scda_serial_t;

	typedef struct packed {
		logic [7:0] dev_cfg;
		logic [7:0] axis_cfg;
		logic [7:0] arm_cfg;
		logic [7:0] thr_pos;
		logic [7:0] thr_neg;
	} scda_cfg_t;

endpackage

// file: verilog/scda_top.sv
`timescale 1ns/1ps

module scda_top (
	input wire logic clk,
	input wire logic sys_rst,
	input wire scda_pkg::scda_req_t req,
	output scda_pkg::scda_rsp_t rsp,
	input wire scda_pkg::scda_otp_t otp_image,
	input wire logic [7:0] event_count,
	input wire logic [7:0] offset_corr,
	input wire logic [7:0] status_in,
	output scda_pkg::scda_cfg_t cfg,
	output scda_pkg::scda_serial_t serial_id,
	output logic otp_valid,
	output logic id_unassigned,
	output logic otp_crc_err,
	output logic wr_crc_err,
	output logic soft_reset
);
	import scda_pkg::*;

	function automatic scda_kind_t addr_kind(input logic [7:0] a);
		case (a)
			OFF_SERIAL_ID_BYTE0, OFF_SERIAL_ID_BYTE1, OFF_SERIAL_ID_BYTE2,
			OFF_SERIAL_ID_BYTE3, OFF_RESERVED_FACTORY_A,
			OFF_RESERVED_FACTORY_B, OFF_FACTORY_CONFIG_BYTE,
			OFF_PART_NUMBER_CODE: addr_kind = K_OTP;
			OFF_DEVICE_CONTROL_REG, OFF_DEVICE_CONFIG_REG,
			OFF_AXIS_CONFIG_REG, OFF_ARMING_CONFIG_REG,
			OFF_ARMING_THRESHOLD_POS_REG,
			OFF_ARMING_THRESHOLD_NEG_REG: addr_kind = K_RW;
			OFF_DEVICE_STATUS_REG, OFF_EVENT_COUNT_REG,
			OFF_OFFSET_CORRECTION_VALUE: addr_kind = K_RO;
			OFF_RESERVED_UPPER_A, OFF_RESERVED_UPPER_B: addr_kind = K_RSVD;
			default: addr_kind = K_INV;
		endcase
	endfunction

	// CRC-8 over the lowest n bytes of v, most significant byte first.
	// Each call unrolls into an 8-step chain per byte (64 steps for the OTP block), so keep it to short blocks.
	function automatic logic [7:0] crc8(input logic [63:0] v, input int n);
		logic [7:0] c;
		c = CRC_INIT;
		for (int b = n - 1; b >= 0; b--) begin
			c = c ^ v[b*8 +: 8];
			for (int i = 0; i < 8; i++) begin
				c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
			end
		end
		return c;
	endfunction

	scda_kind_t kind;
	logic wr_rw;
	logic wr_ctl;
	logic [1:0] res_bits;

	assign kind = addr_kind(req.addr);
	assign wr_rw = req.wr && (kind == K_RW);
	assign wr_ctl = req.wr && (req.addr == OFF_DEVICE_CONTROL_REG);
	assign res_bits = {req.wdata[CTL_RES1_BIT], req.wdata[CTL_RES0_BIT]};

	// OTP shadow: loaded once after reset, never written by the host.
	scda_otp_t otp_q, otp_d;
	logic otp_valid_q, otp_valid_d;
	logic otp_err_q, otp_err_d;
	logic [7:0] otp_crc_now;

	assign otp_crc_now = crc8({otp_q.serial, otp_q.rsv_a, otp_q.rsv_b,
		otp_q.fct_cfg, otp_q.part_num}, OTP_CRC_BYTES);

	always_comb begin
		otp_d = otp_q;
		otp_valid_d = 1'b1;
		otp_err_d = otp_err_q;
		if (!otp_valid_q) begin
			otp_d = otp_image;
		end
		if (otp_valid_q && (otp_crc_now != otp_q.crc)) begin
			otp_err_d = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			otp_q <= '0;
			otp_valid_q <= 1'b0;
			otp_err_q <= 1'b0;
		end else begin
			otp_q <= otp_d;
			otp_valid_q <= otp_valid_d;
			otp_err_q <= otp_err_d;
		end
	end

	// Writable block, reset sequence, writable CRC and reset flag.
	scda_cfg_t cfg_q, cfg_d;
	scda_seq_t seq_q, seq_d;
	logic armed_q, armed_d;
	logic [7:0] wref_q, wref_d;
	logic werr_q, werr_d;
	logic devres_q, devres_d;
	logic fire_q, fire_d;
	logic endinit;
	logic [7:0] wcrc_now;

	assign endinit = cfg_q.dev_cfg[CFG_ENDINIT_BIT];
	assign wcrc_now = crc8({24'h000000, cfg_q}, CFG_CRC_BYTES);

	always_comb begin
		cfg_d = cfg_q;
		seq_d = seq_q;
		armed_d = armed_q;
		wref_d = wref_q;
		werr_d = werr_q;
		devres_d = devres_q;
		fire_d = 1'b0;
		// Once the end-of-init bit is set only the control register
		// accepts writes, so normal traffic cannot disturb settings.
		if (wr_rw && !endinit) begin
			case (req.addr)
				OFF_DEVICE_CONFIG_REG:
					cfg_d.dev_cfg = req.wdata & DEV_CFG_MASK;
				OFF_AXIS_CONFIG_REG:
					cfg_d.axis_cfg = req.wdata & AXIS_MASK;
				OFF_ARMING_CONFIG_REG:
					cfg_d.arm_cfg = req.wdata & ARM_MASK;
				OFF_ARMING_THRESHOLD_POS_REG:
					cfg_d.thr_pos = req.wdata;
				OFF_ARMING_THRESHOLD_NEG_REG:
					cfg_d.thr_neg = req.wdata;
				default: cfg_d = cfg_q;
			endcase
		end
		// Any access other than the next expected control write breaks
		// the reset sequence, including a read of the control register.
		if (req.wr || req.rd) begin
			seq_d = SEQ_IDLE;
		end
		if (wr_ctl) begin
			case (seq_q)
				SEQ_IDLE: if (res_bits == 2'b00) seq_d = SEQ_ONE;
				SEQ_ONE: begin
					if (res_bits == 2'b11) begin
						seq_d = SEQ_TWO;
					end else if (res_bits == 2'b00) begin
						seq_d = SEQ_ONE;
					end
				end
				SEQ_TWO: begin
					if (res_bits == 2'b01) begin
						fire_d = 1'b1;
					end else if (res_bits == 2'b00) begin
						seq_d = SEQ_ONE;
					end
				end
				default: seq_d = SEQ_IDLE;
			endcase
		end
		// The writable CRC only runs while locked; its reference is taken
		// the cycle after the lock closes, when contents are final.
		if (endinit && !armed_q) begin
			armed_d = 1'b1;
			wref_d = wcrc_now;
		end
		if (armed_q && (wcrc_now != wref_q)) begin
			werr_d = 1'b1;
		end
		if (req.rd && (req.addr == OFF_DEVICE_STATUS_REG)) begin
			devres_d = 1'b0;
		end
		if (fire_q) begin
			devres_d = 1'b1;
		end
		if (fire_d) begin
			cfg_d = '0;
			seq_d = SEQ_IDLE;
			armed_d = 1'b0;
			wref_d = CFG_RST;
			werr_d = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cfg_q <= '0;
			seq_q <= SEQ_IDLE;
			armed_q <= 1'b0;
			wref_q <= CFG_RST;
			werr_q <= 1'b0;
			devres_q <= 1'b1;
			fire_q <= 1'b0;
		end else begin
			cfg_q <= cfg_d;
			seq_q <= seq_d;
			armed_q <= armed_d;
			wref_q <= wref_d;
			werr_q <= werr_d;
			devres_q <= devres_d;
			fire_q <= fire_d;
		end
	end

	// Read answer, one cycle after the read strobe.
	scda_rsp_t rsp_q, rsp_d;
	logic [7:0] status_byte;
	// The reset flag is set the cycle after a soft reset fires; a status
	// read in that same cycle cannot clear it, so no reset goes unseen.

	always_comb begin
		status_byte = status_in & STAT_IN_MASK;
		status_byte[STAT_CRC_ERR_BIT] = werr_q | otp_err_q;
		status_byte[STAT_DEVRES_BIT] = devres_q;
	end

	always_comb begin
		rsp_d = '0;
		if (req.rd) begin
			rsp_d.valid = 1'b1;
			case (req.addr)
				OFF_SERIAL_ID_BYTE0: rsp_d.rdata = otp_q.serial[7:0];
				OFF_SERIAL_ID_BYTE1: rsp_d.rdata = otp_q.serial[15:8];
				OFF_SERIAL_ID_BYTE2: rsp_d.rdata = otp_q.serial[23:16];
				OFF_SERIAL_ID_BYTE3: rsp_d.rdata = otp_q.serial[31:24];
				OFF_RESERVED_FACTORY_A: rsp_d.rdata = otp_q.rsv_a;
				OFF_RESERVED_FACTORY_B: rsp_d.rdata = otp_q.rsv_b;
				OFF_FACTORY_CONFIG_BYTE: rsp_d.rdata = otp_q.fct_cfg;
				OFF_PART_NUMBER_CODE: rsp_d.rdata = otp_q.part_num;
				OFF_DEVICE_CONFIG_REG: rsp_d.rdata = cfg_q.dev_cfg;
				OFF_AXIS_CONFIG_REG: rsp_d.rdata = cfg_q.axis_cfg;
				OFF_ARMING_CONFIG_REG: rsp_d.rdata = cfg_q.arm_cfg;
				OFF_ARMING_THRESHOLD_POS_REG: rsp_d.rdata = cfg_q.thr_pos;
				OFF_ARMING_THRESHOLD_NEG_REG: rsp_d.rdata = cfg_q.thr_neg;
				OFF_DEVICE_STATUS_REG: rsp_d.rdata = status_byte;
				OFF_EVENT_COUNT_REG: rsp_d.rdata = event_count;
				OFF_OFFSET_CORRECTION_VALUE: rsp_d.rdata = offset_corr;
				default: rsp_d.rdata = 8'h00;
			endcase
			if (kind == K_INV) begin
				rsp_d.invalid = 1'b1;
				rsp_d.rdata = 8'h00;
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rsp_q <= '0;
		end else begin
			rsp_q <= rsp_d;
		end
	end

	assign rsp = rsp_q;
	assign cfg = cfg_q;
	// The serial identifier drives readback, the OTP CRC, the serial_id output and the id_unassigned flag.
	assign serial_id = otp_q.serial;
	assign otp_valid = otp_valid_q;
	// Zero is never issued as a unit or lot number, so a zero field marks
	// an unprogrammed or damaged identifier.
	assign id_unassigned = otp_valid_q &&
		((serial_id.unit == 13'h0000) ||
		(serial_id.lot == 19'h00000));
	assign otp_crc_err = otp_err_q;
	assign wr_crc_err = werr_q;
	assign soft_reset = fire_q;

	default clocking dc @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	// Registered answers are checked one cycle after the request.

	read_answer_a: assert property (req.rd |=> rsp.valid && !$past(req.wr))
		else $error("read not answered in next cycle");
	invalid_addr_a: assert property (
		req.rd && (kind == K_INV) |=> rsp.invalid && (rsp.rdata == 8'h00))
		else $error("unmapped read did not flag invalid");
	otp_frozen_a: assert property (otp_valid_q |=> $stable(otp_q))
		else $error("otp shadow changed after load");
	lock_hold_a: assert property (
		endinit && !fire_d |=> $stable(cfg_q))
		else $error("locked register changed");
	reserved_read_a: assert property (
		req.rd && (req.addr == OFF_RESERVED_FACTORY_B) |=>
		rsp.rdata == $past(otp_q.rsv_b))
		else $error("reserved byte readback wrong");
	serial_split_a: assert property (
		otp_valid_q |-> serial_id.lot == otp_q.serial[31:SERIAL_LOT_LSB])
		else $error("lot field misplaced");
	otp_crc_a: assert property (
		otp_valid_q && (otp_crc_now != otp_q.crc) |=> otp_crc_err)
		else $error("otp crc mismatch not flagged");
	wr_crc_a: assert property (
		armed_q && (wcrc_now != wref_q) && !fire_d |=> wr_crc_err)
		else $error("writable crc mismatch not flagged");
	reset_seq_a: assert property (
		(wr_ctl && res_bits == 2'b00) ##1 (wr_ctl && res_bits == 2'b11)
		##1 (wr_ctl && res_bits == 2'b01) |=> soft_reset ##1 !endinit)
		else $error("reset sequence did not reset");
	lot_zero_a: assert property (
		otp_valid_q && (otp_q.serial[31:SERIAL_LOT_LSB] == 19'h00000)
		|-> id_unassigned)
		else $error("zero lot not reported");
	unit_zero_a: assert property (
		otp_valid_q && (otp_q.serial[12:0] == 13'h0) |-> id_unassigned)
		else $error("zero unit not reported");
	wr_ignored_a: assert property (
		req.wr && (kind != K_RW) |=> $stable(cfg_q))
		else $error("write to a read-only location took effect");
	serial_byte_a: assert property (
		req.rd && (req.addr == OFF_SERIAL_ID_BYTE3) |=>
		rsp.rdata == $past(serial_id.lot[18:11]))
		else $error("lot bits missing from top serial byte");
	rsp_quiet_a: assert property (
		!req.rd |=> !rsp.valid && !rsp.invalid && (rsp.rdata == 8'h00))
		else $error("answer without a read");
	ctl_read_a: assert property (
		req.rd && (req.addr == OFF_DEVICE_CONTROL_REG) |=>
		rsp.valid && !rsp.invalid && (rsp.rdata == 8'h00))
		else $error("control register read not zero");
	crc_status_a: assert property (
		otp_crc_err || wr_crc_err |-> status_byte[STAT_CRC_ERR_BIT])
		else $error("crc error missing from status");
	devres_set_a: assert property (fire_q |=> devres_q)
		else $error("reset flag not set after soft reset");

	invalid_read_c: cover property (req.rd && kind == K_INV ##1 rsp.invalid);
	locked_write_c: cover property (endinit && wr_rw ##1 $stable(cfg_q));
	soft_reset_c: cover property (soft_reset ##1 devres_q);
	otp_error_c: cover property (otp_valid_q ##1 otp_crc_err);

endmodule

// file: verif/scda_host.sv
`timescale 1ns/1ps

// Behavioural register-bus master standing in for the host controller.
module scda_host (
	input wire logic clk,
	input wire scda_pkg::scda_rsp_t rsp,
	output scda_pkg::scda_req_t req
);
	import scda_pkg::*;

	int addr_errs = 0;

	initial req = '0;

	// Each request is held for one edge; the next call replaces it, so
	// strobes can follow back to back without a second assignment.
	task automatic acc(logic w, logic r, logic [7:0] a, logic [7:0] d);
		req <= '{addr: a, wdata: d, wr: w, rd: r};
		@(posedge clk);
	endtask

	// An invalid answer is an addressing error, never register content.
	always @(posedge clk) begin
		if (rsp.valid === 1'b1 && rsp.invalid === 1'b1)
			addr_errs++;
	end
endmodule

// file: verif/sensor_config_data_array_test.sv
`timescale 1ns/1ps

module sensor_config_data_array_test;
	import scda_pkg::*;

	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	scda_req_t req;
	scda_rsp_t rsp;
	scda_otp_t otp = '0;
	logic [7:0] evc = 8'h00;
	logic [7:0] offc = 8'h00;
	logic [7:0] sti = 8'h00;
	scda_cfg_t cfg;
	scda_serial_t sid;
	logic otp_valid, id_unas, otp_err, wr_err, soft_rst;
	int num_errors = 0;
	int checked = 0;
	int soft_cnt = 0;
	logic [8:0] exp_q[$];
	logic [7:0] ra[5] = '{8'h0B, 8'h0C, 8'h0E, 8'h10, 8'h12};
	logic [7:0] rm[5] = '{8'h3F, 8'h8F, 8'h3F, 8'hFF, 8'hFF};
	logic [7:0] ev[5];
	logic [7:0] un[9] = '{8'h07, 8'h09, 8'h0D, 8'h0F, 8'h11, 8'h13,
		8'h17, 8'h18, 8'h1E};

	always #10 clk = ~clk;

	scda_host u_host (.clk(clk), .rsp(rsp), .req(req));

	scda_top u_dut (.clk(clk), .sys_rst(sys_rst), .req(req), .rsp(rsp),
		.otp_image(otp), .event_count(evc), .offset_corr(offc),
		.status_in(sti), .cfg(cfg), .serial_id(sid),
		.otp_valid(otp_valid), .id_unassigned(id_unas),
		.otp_crc_err(otp_err), .wr_crc_err(wr_err),
		.soft_reset(soft_rst));

	task automatic check(string nm, logic [39:0] seen, logic [39:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Answers arrive one cycle after the read, so the oldest note matches.
	always @(posedge clk) begin
		if (rsp.valid === 1'b1) begin
			if (exp_q.size() == 0)
				check("rsp_extra", 1, 0);
			else
				check("rsp", {rsp.invalid, rsp.rdata},
					exp_q.pop_front());
		end
	end

	always @(posedge clk) begin
		if (soft_rst === 1'b1)
			soft_cnt++;
	end

	task automatic wr(logic [7:0] a, logic [7:0] d);
		u_host.acc(1'b1, 1'b0, a, d);
	endtask

	task automatic rd(logic [7:0] a, logic [8:0] e);
		exp_q.push_back(e);
		u_host.acc(1'b0, 1'b1, a, 8'h00);
	endtask

	task automatic idle(int n);
		u_host.acc(1'b0, 1'b0, 8'h00, 8'h00);
		repeat (n) @(posedge clk);
	endtask

	function automatic logic [7:0] crc8(logic [63:0] m);
		logic [7:0] c;
		c = 8'hFF;
		for (int i = 63; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ m[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction

	function automatic logic [8:0] stat(logic res, logic err);
		return {1'b0, (sti & 8'h3A) | {1'b0, err, 5'h00, res}};
	endfunction

	task automatic phase(logic bad, logic [18:0] lot, logic [12:0] unit);
		scda_otp_t o;
		logic [7:0] ob[9];
		o.serial = {lot, unit};
		{o.rsv_a, o.rsv_b, o.fct_cfg, o.part_num} = $urandom;
		o.crc = crc8(o[71:8]) ^ {7'h00, bad};
		otp <= o;
		evc <= $urandom;
		offc <= $urandom;
		sti <= $urandom;
		sys_rst <= 1'b1;
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (3) @(posedge clk);
		check("otp_valid", otp_valid, 1);
		check("serial_id", sid, {lot, unit});
		check("id_unassigned", id_unas, lot == 0 || unit == 0);
		check("otp_crc_err", otp_err, bad);
		check("wr_crc_err", wr_err, 0);
		ob = '{o.serial[7:0], o.serial[15:8], o.serial[23:16],
			o.serial[31:24], o.rsv_a, o.rsv_b, o.fct_cfg, 8'h00, o.part_num};
		for (int k = 0; k < 9; k++)
			rd(8'(k), {k == 7, ob[k]});
		for (int k = 0; k < 9; k++)
			wr(8'(k), ~ob[k]);
		for (int k = 0; k < 9; k++)
			rd(8'(k), {k == 7, ob[k]});
		rd(OFF_DEVICE_STATUS_REG, stat(1'b1, bad));
		rd(OFF_DEVICE_STATUS_REG, stat(1'b0, bad));
		idle(2);
		check("rsp_pending", exp_q.size(), 0);
		$display("otp phase done lot %0h unit %0h", lot, unit);
	endtask

	initial begin
		logic [7:0] d;
		void'($urandom(32'h4E17A6BD));
		@(posedge clk);
		phase(1'b0, 19'($urandom_range(1, 19'h7FFFF)),
			13'($urandom_range(1, 13'h1FFF)));
		phase(1'b1, 19'($urandom_range(1, 19'h7FFFF)), 13'h0000);
		phase(1'b0, 19'h00000, 13'($urandom_range(1, 13'h1FFF)));
		for (int k = 0; k < 9; k++)
			rd(un[k], 9'h100);
		rd(OFF_RESERVED_UPPER_A, 9'h000);
		rd(OFF_RESERVED_UPPER_B, 9'h000);
		rd(OFF_EVENT_COUNT_REG, {1'b0, evc});
		rd(OFF_OFFSET_CORRECTION_VALUE, {1'b0, offc});
		rd(OFF_DEVICE_CONTROL_REG, 9'h000);
		$display("map test done");
		// The lock bit stays clear here so that every register takes data.
		for (int k = 0; k < 5; k++) begin
			d = $urandom;
			if (k == 0)
				d[5] = 1'b0;
			ev[k] = d & rm[k];
			wr(ra[k], d);
		end
		for (int k = 0; k < 5; k++)
			rd(ra[k], {1'b0, ev[k]});
		check("cfg", cfg, {ev[0], ev[1], ev[2], ev[3], ev[4]});
		ev[0][5] = 1'b1;
		wr(ra[0], ev[0]);
		for (int k = 0; k < 5; k++)
			wr(ra[k], ~ev[k]);
		for (int k = 0; k < 5; k++)
			rd(ra[k], {1'b0, ev[k]});
		idle(3);
		check("wr_crc_err", wr_err, 0);
		$display("lock test done");
		// A read inside the sequence must cancel it.
		wr(OFF_DEVICE_CONTROL_REG, 8'h00);
		wr(OFF_DEVICE_CONTROL_REG, 8'hC0);
		rd(OFF_DEVICE_CONTROL_REG, 9'h000);
		wr(OFF_DEVICE_CONTROL_REG, 8'h40);
		idle(4);
		check("soft_reset", soft_cnt, 0);
		wr(OFF_DEVICE_CONTROL_REG, 8'h00);
		wr(OFF_DEVICE_CONTROL_REG, 8'hC0);
		wr(OFF_DEVICE_CONTROL_REG, 8'h40);
		idle(4);
		check("soft_reset", soft_cnt, 1);
		check("cfg", cfg, 0);
		rd(OFF_DEVICE_STATUS_REG, stat(1'b1, 1'b0));
		wr(ra[0], 8'h15);
		rd(ra[0], 9'h015);
		idle(2);
		check("rsp_pending", exp_q.size(), 0);
		check("addr_errs", u_host.addr_errs, 15);
		$display("soft reset test done");
		print_verdict();
	end

	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		$display("watchdog expired");
		print_verdict();
	end
endmodule
